/* File: verilog/two_level_irq_controller.sv */
// primary two-level interrupt controller with optional secondary unit
// assumes an APB master and a processor core that acknowledges by index
// Functional notes
// RQ1: level bits 31..17 put interrupt n on level 1 when set.
// RQ2: mask bits 15..1 enable interrupts; reset clears them; 16 and 0 reserved.
// RQ3: pending register bits 15..1 show pending interrupts.
// RQ4: force bits 15..1 request an interrupt as if pending.
// RQ5: clear register ones clear pending bits; reads return zero.
// RQ6: map register low holds route fields for bus lines 1..7.
// RQ7: map register high holds route fields for bus lines 8..14 and 15.
// RQ8: route fields reset to identity mapping.
// RQ9: up to 32 secondary inputs; unused ones have no bits.
// RQ10: each secondary input qualified low, high, falling or rising.
// RQ11: qualified inputs set pending; pending and mask feed selector.
// RQ12: any unmasked secondary pending raises primary line 10 by default.
// RQ13: secondary pending stays set until software clears it.
// RQ14: handler must clear primary line 10 after secondary clear.
// RQ15: writing secondary pending sets bits written as one.
// RQ16: secondary mask enables per input; resets to zero.
// RQ17: secondary pending bits report and reset to zero.
// RQ18: secondary status gives highest index and valid flag.
// RQ19: secondary clear ones clear matching pending bits.
// RQ20: level 1 highest wins; else level 0 highest.
// RQ21: acknowledge clears pending bit of a pending-raised interrupt.
// RQ22: acknowledge of a forced interrupt clears force, keeps pending.
// RQ23: bus lines routed to one processor line are ORed.
// RQ24: reserved bits read zero and ignore writes.
`timescale 1ns/1ns
module two_level_irq_controller
	import irq_ctrl_pkg::*;
#(
	parameter bit REMAP_EN = 1'b1,
	parameter bit SEC_EN = 1'b1,
	parameter int SEC_N = 32,
	parameter int SEC_LINE = 10,
	parameter logic [63:0] SEC_COND = 64'h5555_5555_5555_5555,
	parameter int PADDR_W = 32
) (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [PADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	input wire logic [15:1] BUS_IRQ_I,
	input wire logic [SEC_N-1:0] SEC_IRQ_I,
	input wire logic INTACK_I,
	input wire logic [3:0] ACK_INDEX_I,
	output logic [3:0] HIGHEST_REQUEST_INDEX_O,
	output logic SEC_IRQ_O
);
	generate
		if (SEC_N < 1 || SEC_N > SEC_MAX) begin : g_bad_n
			$error("SEC_N must be 1 to 32");
		end
		if (SEC_LINE < 1 || SEC_LINE > NUM_LINES) begin : g_bad_line
			$error("SEC_LINE must be 1 to 15");
		end
		if (PADDR_W < ADDR_DEC_W) begin : g_bad_addr
			$error("PADDR_W too small");
		end
	endgenerate

	logic [15:1] level_r;
	logic [15:1] enable_bits_r;
	logic [15:1] waiting_bits_r;
	logic [15:1] waiting_bits_nxt;
	logic [15:1] software_raise_bits_r;
	logic [15:1] software_raise_bits_nxt;
	logic [3:0] line_route_field_r [1:15];
	logic [SEC_N-1:0] sec_mask_r;
	logic [SEC_N-1:0] sec_pend_r;
	logic [SEC_N-1:0] sec_pend_nxt;
	logic [SEC_N-1:0] sec_hit;
	logic [SEC_N-1:0] sec_active;
	logic [SEC_IDX_W-1:0] sec_idx;
	logic sec_out_r;
	logic [15:1] routed;
	logic [15:1] raised;
	logic [15:1] requested;
	logic [3:0] irl_nxt;
	logic [3:0] irl_r;
	logic [15:1] ack_vec;
	logic [31:0] rdata_nxt;
	logic [31:0] prdata_r;
	logic [ADDR_DEC_W-1:0] ofs;
	logic wr_en;
	logic rd_setup;

	assign ofs = PADDR_I[ADDR_DEC_W-1:0];
	assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
	assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;

	function automatic logic [3:0] top_index(input logic [15:1] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 1; i <= NUM_LINES; i++) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : top_index

	// RQ1: level field write
	// RQ2: mask field write, reset to zero
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			level_r <= '0;
			enable_bits_r <= MASK_RESET;
		end else if (wr_en && ofs == OFS_MASK_LEVEL) begin
			level_r <= PWDATA_I[LEVEL_LSB +: NUM_LINES];
			enable_bits_r <= PWDATA_I[MASK_LSB +: NUM_LINES];
		end
	end

	// RQ6: low route fields
	// RQ7: high route fields
	// RQ8: identity after reset
	genvar b;
	generate
		for (b = 1; b <= NUM_LINES; b++) begin : g_map
			localparam int REG_SEL = (b <= MAP_FIELDS_PER_REG) ? 0 : 1;
			localparam int POS = (b <= MAP_FIELDS_PER_REG) ? (MAP_FIELDS_PER_REG - b)
				: (2 * MAP_FIELDS_PER_REG - b);
			// line 15 has no field of its own and takes line 14's field on map high writes
			localparam int LSB = (b == NUM_LINES) ? 0 : POS * MAP_FIELD_W;
			localparam logic [7:0] OFS = (REG_SEL == 0) ? OFS_MAP_LOW : OFS_MAP_HIGH;
			always_ff @(posedge CLK_I or negedge RSTN_I) begin
				if (!RSTN_I) begin
					line_route_field_r[b] <= 4'(b);
				end else if (REMAP_EN && wr_en && ofs == OFS) begin
					line_route_field_r[b] <= PWDATA_I[LSB +: MAP_FIELD_W];
				end
			end
		end
	endgenerate

	// RQ23: routed lines are ORed
	always_comb begin
		routed = '0;
		for (int p = 1; p <= NUM_LINES; p++) begin
			for (int q = 1; q <= NUM_LINES; q++) begin
				if (REMAP_EN) begin
					routed[p] = routed[p] | (BUS_IRQ_I[q] && line_route_field_r[q] == 4'(p));
				end else if (p == q) begin
					routed[p] = routed[p] | BUS_IRQ_I[q];
				end
			end
		end
	end

	// RQ12: secondary output joins its primary line
	always_comb begin
		// joins after routing, so remapping never moves the secondary line
		raised = routed;
		if (SEC_EN) begin
			raised[SEC_LINE] = routed[SEC_LINE] | sec_out_r;
		end
	end

	always_comb begin
		ack_vec = '0;
		// index 0 names no request and is ignored
		if (INTACK_I && ACK_INDEX_I != 4'h0) begin
			ack_vec[ACK_INDEX_I] = 1'b1;
		end
	end

	// RQ3: pending bits set by raised lines
	// RQ5: clear register ones clear, new event wins
	// RQ21: acknowledge clears pending when not forced
	always_comb begin
		waiting_bits_nxt = waiting_bits_r & ~(ack_vec & ~software_raise_bits_r);
		if (wr_en && ofs == OFS_CLEAR) begin
			waiting_bits_nxt = waiting_bits_nxt & ~PWDATA_I[MASK_LSB +: NUM_LINES];
		end
		// applied last: a clear never swallows a fresh request
		waiting_bits_nxt = waiting_bits_nxt | raised;
	end

	// RQ4: software raise written by software
	// RQ22: acknowledge of a forced line clears force only
	always_comb begin
		software_raise_bits_nxt = software_raise_bits_r & ~ack_vec;
		if (wr_en && ofs == OFS_FORCE) begin
			software_raise_bits_nxt = PWDATA_I[MASK_LSB +: NUM_LINES];
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			waiting_bits_r <= '0;
			software_raise_bits_r <= '0;
		end else begin
			waiting_bits_r <= waiting_bits_nxt;
			software_raise_bits_r <= software_raise_bits_nxt;
		end
	end

	// RQ20: level 1 first, then level 0
	assign requested = (waiting_bits_r | software_raise_bits_r) & enable_bits_r;
	always_comb begin
		if (|(requested & level_r)) begin
			irl_nxt = top_index(requested & level_r);
		end else begin
			irl_nxt = top_index(requested & ~level_r);
		end
	end

	// one cycle of selection latency keeps the output registered
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			irl_r <= 4'h0;
		end else begin
			irl_r <= irl_nxt;
		end
	end

	// RQ9: only configured inputs get bits
	// RQ10: per-input qualifier
	sec_input_qualify #(
		.N(SEC_N),
		.COND(SEC_COND)
	) u_qualify (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.raw_i(SEC_IRQ_I),
		.hit_o(sec_hit)
	);

	// RQ16: secondary mask, zero at reset
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sec_mask_r <= '0;
		end else if (SEC_EN && wr_en && ofs == OFS_SEC_MASK) begin
			sec_mask_r <= PWDATA_I[SEC_N-1:0];
		end
	end

	// RQ13: no clear on acknowledge
	// RQ19: clear by writing ones
	// RQ15: write ones to set
	// RQ11: qualified input sets pending, wins over clear
	always_comb begin
		sec_pend_nxt = sec_pend_r;
		if (wr_en && ofs == OFS_SEC_CLEAR) begin
			sec_pend_nxt = sec_pend_nxt & ~PWDATA_I[SEC_N-1:0];
		end
		if (wr_en && ofs == OFS_SEC_PENDING) begin
			sec_pend_nxt = sec_pend_nxt | PWDATA_I[SEC_N-1:0];
		end
		sec_pend_nxt = sec_pend_nxt | sec_hit;
	end

	// RQ17: secondary pending, zero at reset
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sec_pend_r <= '0;
		end else if (SEC_EN) begin
			sec_pend_r <= sec_pend_nxt;
		end
	end

	// RQ11: pending ANDed with mask
	assign sec_active = sec_pend_r & sec_mask_r;

	// RQ12: output while any unmasked pending
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sec_out_r <= 1'b0;
		end else begin
			sec_out_r <= SEC_EN & (|sec_active);
		end
	end

	// RQ18: highest unmasked pending index
	always_comb begin
		sec_idx = '0;
		for (int i = 0; i < SEC_N; i++) begin
			if (sec_active[i]) begin
				sec_idx = SEC_IDX_W'(i);
			end
		end
	end

	// RQ24: reserved bits and unmapped offsets read zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (ofs)
			OFS_MASK_LEVEL: begin
				rdata_nxt[LEVEL_LSB +: NUM_LINES] = level_r;
				rdata_nxt[MASK_LSB +: NUM_LINES] = enable_bits_r;
			end
			OFS_PENDING: rdata_nxt[MASK_LSB +: NUM_LINES] = waiting_bits_r;
			OFS_FORCE: rdata_nxt[MASK_LSB +: NUM_LINES] = software_raise_bits_r;
			OFS_MAP_LOW: begin
				for (int k = 1; k <= MAP_FIELDS_PER_REG; k++) begin
					if (REMAP_EN) begin
						rdata_nxt[(MAP_FIELDS_PER_REG - k) * MAP_FIELD_W +: MAP_FIELD_W] =
							line_route_field_r[k];
					end
				end
			end
			OFS_MAP_HIGH: begin
				for (int k = MAP_FIELDS_PER_REG + 1; k < NUM_LINES; k++) begin
					if (REMAP_EN) begin
						rdata_nxt[(2 * MAP_FIELDS_PER_REG - k) * MAP_FIELD_W +: MAP_FIELD_W] =
							line_route_field_r[k];
					end
				end
			end
			OFS_SEC_MASK: rdata_nxt[SEC_N-1:0] = sec_mask_r;
			OFS_SEC_PENDING: rdata_nxt[SEC_N-1:0] = sec_pend_r;
			OFS_SEC_STATUS: begin
				rdata_nxt[SEC_IDX_W-1:0] = sec_idx;
				rdata_nxt[SEC_VALID_BIT] = |sec_active;
			end
			default: rdata_nxt = 32'h0000_0000;
		endcase
		if (!SEC_EN && (ofs == OFS_SEC_MASK || ofs == OFS_SEC_PENDING
				|| ofs == OFS_SEC_STATUS)) begin
			rdata_nxt = 32'h0000_0000;
		end
	end

	// read data captured in setup phase, stable through access phase
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_r <= rdata_nxt;
		end
	end

	assign PRDATA_O = prdata_r;
	assign HIGHEST_REQUEST_INDEX_O = irl_r;
	assign SEC_IRQ_O = sec_out_r;
endmodule : two_level_irq_controller

/* File: verilog/irq_ctrl_pkg.sv */
// constants shared by the two-level interrupt controller files
// assumes word-aligned register access over the peripheral bus
package irq_ctrl_pkg;
	// register byte offsets, low address bits only
	localparam logic [7:0] OFS_MASK_LEVEL = 8'h90;
	localparam logic [7:0] OFS_PENDING = 8'h94;
	localparam logic [7:0] OFS_FORCE = 8'h98;
	localparam logic [7:0] OFS_CLEAR = 8'h9C;
	localparam logic [7:0] OFS_SEC_MASK = 8'hB0;
	localparam logic [7:0] OFS_SEC_PENDING = 8'hB4;
	// status is read here, the clear register is written here
	localparam logic [7:0] OFS_SEC_STATUS = 8'hB8;
	localparam logic [7:0] OFS_SEC_CLEAR = 8'hB8;
	localparam logic [7:0] OFS_MAP_LOW = 8'hE0;
	localparam logic [7:0] OFS_MAP_HIGH = 8'hE4;
	localparam int ADDR_DEC_W = 8;

	// primary field layout
	localparam int NUM_LINES = 15;
	localparam int LEVEL_LSB = 17;
	localparam int MASK_LSB = 1;
	localparam logic [14:0] MASK_RESET = 15'h0000;

	// line route fields: seven 4-bit fields per map register, msb field first
	localparam int MAP_FIELD_W = 4;
	localparam int MAP_FIELDS_PER_REG = 7;
	localparam int MAP_TOP_LSB = 24;

	// secondary status layout
	localparam int SEC_VALID_BIT = 5;
	localparam int SEC_IDX_W = 5;
	localparam int SEC_MAX = 32;

	// per-input qualifying condition
	typedef enum logic [1:0] {
		COND_LOW = 2'h0,
		COND_HIGH = 2'h1,
		COND_FALL = 2'h2,
		COND_RISE = 2'h3
	} cond_t;
endpackage : irq_ctrl_pkg

/* File: verilog/sec_input_qualify.sv */
// per-input condition qualifier for the secondary interrupt inputs
// assumes inputs are synchronous to the clock
`timescale 1ns/1ns
module sec_input_qualify
	import irq_ctrl_pkg::*;
#(
	parameter int N = 32,
	parameter logic [63:0] COND = 64'h0
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [N-1:0] raw_i,
	output logic [N-1:0] hit_o
);
	logic [N-1:0] prev_r;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev_r <= '0;
		end else begin
			prev_r <= raw_i;
		end
	end

	// RQ10: four conditions per input
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_in
			localparam cond_t C = cond_t'(COND[2*g +: 2]);
			always_comb begin
				case (C)
					COND_LOW: hit_o[g] = ~raw_i[g];
					COND_HIGH: hit_o[g] = raw_i[g];
					COND_FALL: hit_o[g] = prev_r[g] & ~raw_i[g];
					COND_RISE: hit_o[g] = ~prev_r[g] & raw_i[g];
					default: hit_o[g] = 1'b0;
				endcase
			end
		end
	endgenerate
endmodule : sec_input_qualify

/* File: tb/irq_ctrl_checker_properties.sv */
// assertions on the controller's bus and request outputs
// bound to two_level_irq_controller; sees its ports only
`timescale 1ns/1ns
module irq_ctrl_checker
	import irq_ctrl_pkg::*;
#(
	parameter int PADDR_W = 32
) (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [PADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic [3:0] HIGHEST_REQUEST_INDEX_O,
	input wire logic SEC_IRQ_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	wire logic rd = PSEL_I && !PENABLE_I && !PWRITE_I;
	wire logic wr = PSEL_I && PENABLE_I && PWRITE_I;
	wire logic [7:0] a = PADDR_I[7:0];
	rst_idle_a: assert property (
		$rose(RSTN_I) |-> HIGHEST_REQUEST_INDEX_O == 4'h0 && !SEC_IRQ_O) else $error("not idle");
	clr_reads_a: assert property (
		rd && a == OFS_CLEAR |=> PRDATA_O == 32'h0) else $error("clear reads nonzero");
	mask_rsvd_a: assert property (
		rd && a == OFS_MASK_LEVEL |=> !PRDATA_O[16] && !PRDATA_O[0]) else $error("mask rsvd");
	pend_rsvd_a: assert property (
		rd && (a == OFS_PENDING || a == OFS_FORCE) |=> PRDATA_O[31:16] == 16'h0 && !PRDATA_O[0])
		else $error("pending rsvd");
	map_rsvd_a: assert property (
		rd && (a == OFS_MAP_LOW || a == OFS_MAP_HIGH) |=> PRDATA_O[31:28] == 4'h0)
		else $error("map rsvd");
	stat_rsvd_a: assert property (
		rd && a == OFS_SEC_STATUS |=> PRDATA_O[31:6] == 26'h0) else $error("status rsvd");
	unmapped_zero_a: assert property (
		rd && a < OFS_MASK_LEVEL |=> PRDATA_O == 32'h0) else $error("unmapped nonzero");
	mask_off_a: assert property (
		wr && a == OFS_MASK_LEVEL && PWDATA_I[15:1] == 15'h0
		|-> ##2 HIGHEST_REQUEST_INDEX_O == 4'h0) else $error("masked index shown");
	sec_off_a: assert property (
		wr && a == OFS_SEC_MASK && PWDATA_I == 32'h0 |-> ##2 !SEC_IRQ_O) else $error("sec masked");
	cover property (HIGHEST_REQUEST_INDEX_O == 4'h3 ##1 HIGHEST_REQUEST_INDEX_O == 4'h9);
	cover property ($rose(SEC_IRQ_O));
	cover property (wr && a == OFS_SEC_PENDING);
endmodule : irq_ctrl_checker
bind two_level_irq_controller irq_ctrl_checker #(.PADDR_W(PADDR_W)) u_chk (.CLK_I(CLK_I),
	.RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
	.PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
	.HIGHEST_REQUEST_INDEX_O(HIGHEST_REQUEST_INDEX_O), .SEC_IRQ_O(SEC_IRQ_O));

/* File: tb/irq_core_model.sv */
// processor core model: acknowledges the presented interrupt index
// assumes the index output is registered on the rising clock edge
`timescale 1ns/1ns
module irq_core_model (
	input wire logic clk_i,
	input wire logic en_i,
	input wire logic [3:0] idx_i,
	output logic ack_o,
	output logic [3:0] ack_idx_o
);
	logic [3:0] k;
	initial begin
		ack_o = 1'b0;
		ack_idx_o = 4'h0;
		forever begin
			@(posedge clk_i);
			if (en_i && idx_i != 4'h0) begin
				k = idx_i;
				#1 ack_o = 1'b1;
				ack_idx_o = k;
				@(posedge clk_i);
				#1 ack_o = 1'b0;
				// released index shows a changed value, not the last one
				ack_idx_o = ~k;
				// slow core, so software can look at registers between acks
				repeat (12) @(posedge clk_i);
			end
		end
	end
endmodule : irq_core_model

/* File: tb/tb_two_level_irq_controller.sv */
// self-checking bench for the two-level interrupt controller
// assumes irq_core_model answers requests on the core side
`timescale 1ns/1ns
module tb_two_level_irq_controller;
	logic clk, rstn, psel, pen, pwr, en, ack, sec_o;
	logic [31:0] padr, pwd, prd, rdv, sec;
	logic [15:1] bus;
	logic [3:0] aidx, idx;
	logic [11:0] seq = 12'h0;
	int miscompares, samples_checked;
	logic [7:0] ra [10] = '{8'h90, 8'h94, 8'h98, 8'h9C, 8'hE0, 8'hE4, 8'hB0, 8'hB4, 8'hB8, 8'h00};
	logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h01234567, 32'h089ABCDE, 32'h0,
		32'h0, 32'h0, 32'h0};
	// inputs 0..3 qualified low, high, falling, rising
	two_level_irq_controller #(.SEC_COND(64'h5555_5555_5555_55E4)) u_dut (.CLK_I(clk),
		.RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr),
		.PWDATA_I(pwd), .PRDATA_O(prd), .BUS_IRQ_I(bus), .SEC_IRQ_I(sec), .INTACK_I(ack),
		.ACK_INDEX_I(aidx), .HIGHEST_REQUEST_INDEX_O(idx), .SEC_IRQ_O(sec_o));
	irq_core_model u_core (.clk_i(clk), .en_i(en), .idx_i(idx), .ack_o(ack), .ack_idx_o(aidx));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (ack) seq <= {seq[7:0], aidx};
	task automatic conclude();
		if (miscompares == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel = 1'b1;
		pwr = w;
		padr = {24'h800000, a};
		pwd = d;
		@(posedge clk);
		#1 pen = 1'b1;
		@(posedge clk);
		rdv = prd;
		#1 psel = 1'b0;
		pen = 1'b0;
		cyc(1);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask : rd
	task automatic pulse(input logic [15:0] v);
		bus = v[15:1];
		cyc(1);
		bus = 15'h0;
	endtask : pulse
	task automatic waitack();
		int n;
		@(posedge clk);
		for (n = 0; n < 100 && !ack; n++) @(posedge clk);
		if (!ack) begin
			miscompares++;
			conclude();
		end
		#1;
	endtask : waitack
	initial begin
		{rstn, psel, pen, pwr, en} = 5'h0;
		{padr, pwd, bus} = '0;
		sec = 32'h1;
		miscompares = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk);
		#1 rstn = 1'b1;
		for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
		wr(8'h90, 32'h00090229);
		rd(8'h90, 32'h00080228);
		pulse(16'h0228);
		rd(8'h94, 32'h228);
		chk(idx, 4'h3);
		en = 1'b1;
		cyc(60);
		en = 1'b0;
		chk(seq, 12'h395);
		rd(8'h94, 32'h0);
		wr(8'h90, 32'h80);
		wr(8'h98, 32'h00010081);
		pulse(16'h0080);
		rd(8'h98, 32'h80);
		chk(idx, 4'h7);
		en = 1'b1;
		waitack();
		rd(8'h98, 32'h0);
		rd(8'h94, 32'h80);
		waitack();
		en = 1'b0;
		cyc(2);
		rd(8'h94, 32'h0);
		wr(8'h90, 32'h0);
		pulse(16'h0010);
		cyc(2);
		chk(idx, 4'h0);
		wr(8'h9C, 32'h11);
		rd(8'h94, 32'h0);
		wr(8'hE0, 32'h06634567);
		pulse(16'h0002);
		rd(8'h94, 32'h40);
		wr(8'h9C, 32'h40);
		pulse(16'h0004);
		rd(8'h94, 32'h40);
		wr(8'hE4, 32'h0C9ABCDE);
		rd(8'hE4, 32'h0C9ABCDE);
		pulse(16'h0100);
		rd(8'h94, 32'h1040);
		wr(8'hE0, 32'h01234567);
		wr(8'hE4, 32'h089ABCDE);
		wr(8'h9C, 32'hFFFE);
		sec = 32'hE;
		cyc(1);
		sec = 32'h3;
		cyc(1);
		sec = 32'h1;
		cyc(2);
		rd(8'hB4, 32'hF);
		rd(8'hB8, 32'h0);
		chk(sec_o, 1'b0);
		wr(8'hB0, 32'hA);
		chk(sec_o, 1'b1);
		rd(8'hB8, 32'h23);
		rd(8'h94, 32'h400);
		wr(8'h90, 32'h400);
		en = 1'b1;
		waitack();
		en = 1'b0;
		chk(seq[3:0], 4'hA);
		rd(8'hB4, 32'hF);
		wr(8'hB8, 32'h8);
		rd(8'hB4, 32'h7);
		wr(8'hB4, 32'h10000000);
		rd(8'hB4, 32'h10000007);
		rd(8'hB8, 32'h21);
		wr(8'hB8, 32'hFFFFFFFF);
		cyc(2);
		chk(sec_o, 1'b0);
		wr(8'h9C, 32'h400);
		rd(8'h94, 32'h0);
		wr(8'hB0, 32'h0);
		conclude();
	end
endmodule : tb_two_level_irq_controller
